// ---- dsm_diag.sv ----
/*
 * Diagnostic status block: control register with memory test and self-test
 * requests, and the sticky diagnostic status word read by the host.
 * Assumes the serial port decode supplies one-cycle write and read strobes,
 * sample_tick marks each sample cycle, and the self-test engine and supply
 * monitors are outside.
 */
// What this block does
// - Writing memory-test bit starts a checksum check over flash.
// - Checksum outcome goes to status bit 6, one meaning fail.
// - Memory-test bit clears itself when the check finishes.
// - A status read clears every error flag but supply bits 1 and 0.
// - A condition still present sets its flag again next sample cycle.
// - Supply flags bits 1 and 0 do not need a read to clear.
// - Supply flags clear themselves when supply returns in range.
// - Bit 1 shows supply above 5.25 V.
// - Bits 15..13 show accelerometer Z, Y, X self-test failure.
// - Bits 12..10 show gyroscope Z, Y, X self-test failure.
// - Bits 9 and 8 show alarm 2 and alarm 1 active.
// - Bit 5 shows overall self-test failure.
// - Bit 4 shows a sensor over its range.
// - Bit 3 shows a serial link failure.
// - Bit 2 shows a failed flash update.
// - Status resets to zero and bit 7 always reads zero.
// - Self-test enable runs the sensor self-test and records results.
`timescale 1ns/1ps
module dsm_diag #(
  parameter int unsigned FLASH_ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Control register access.
  input  wire logic                    ctrl_wr_en,
  input  wire logic [15:0]             ctrl_wr_data,
  output logic [15:0]                  ctrl_rd_data,
  // Status register access.
  input  wire logic                    stat_rd_en,
  output logic [15:0]                  stat_rd_data,
  // Sample timing and fault sources.
  input  wire logic                    sample_tick,
  input  wire logic [1:0]              alarm_active,
  input  wire logic                    overrange,
  input  wire logic                    link_fail,
  input  wire logic                    flash_update_fail,
  input  wire logic                    supply_over,
  input  wire logic                    supply_under,
  // Self-test engine.
  output logic                         selftest_start,
  input  wire logic                    selftest_done,
  input  wire logic [5:0]              selftest_fail,
  // Flash read port.
  output logic [FLASH_ADDR_W-1:0]      flash_addr,
  input  wire logic [15:0]             flash_rdata
);
  initial begin
    if (FLASH_ADDR_W < 2) begin
      $error("dsm_diag: flash needs at least four words");
    end
  end

  // ==========================================================================
  // Reset release.
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Memory test engine.
  logic mem_start;
  logic mem_busy;
  logic mem_done;
  logic mem_fail;

  dsm_memtest #(
    .ADDR_W (FLASH_ADDR_W),
    .DATA_W (16)
  ) u_memtest (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .start       (mem_start),
    .busy        (mem_busy),
    .done        (mem_done),
    .fail        (mem_fail),
    .flash_addr  (flash_addr),
    .flash_rdata (flash_rdata)
  );

  // ==========================================================================
  // Control register.
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;

  assign mem_start = ctrl_wr_en && ctrl_wr_data[dsm_pkg::BIT_MEM_TEST]
                     && !ctrl[dsm_pkg::BIT_MEM_TEST] && !mem_busy;
  assign selftest_start = ctrl_wr_en
                     && ctrl_wr_data[dsm_pkg::BIT_SELF_TEST]
                     && !ctrl[dsm_pkg::BIT_SELF_TEST];

  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr_en) begin
      // A running test cannot be withdrawn by writing its bit low.
      next_ctrl = (ctrl_wr_data & dsm_pkg::CTRL_MASK)
                | (ctrl & 16'h0C00);
    end
    if (mem_done) begin
      next_ctrl[dsm_pkg::BIT_MEM_TEST] = 1'b0;
    end
    if (selftest_done) begin
      next_ctrl[dsm_pkg::BIT_SELF_TEST] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= dsm_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  assign ctrl_rd_data = ctrl;

  // ==========================================================================
  // Latched test outcomes, which stand as conditions until the next run.
  logic [5:0] st_result;
  logic [5:0] next_st_result;
  logic       mem_result;
  logic       next_mem_result;

  always_comb begin
    next_st_result  = selftest_done ? selftest_fail : st_result;
    next_mem_result = mem_done ? mem_fail : mem_result;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_result  <= '0;
      mem_result <= 1'b0;
    end else begin
      st_result  <= next_st_result;
      mem_result <= next_mem_result;
    end
  end

  // ==========================================================================
  // Status word.
  logic [15:0] status;
  logic [15:0] next_status;
  logic [15:0] cond;
  logic [15:0] event_now;

  always_comb begin
    cond = '0;
    cond[dsm_pkg::BIT_ACC_Z:dsm_pkg::BIT_GYR_X] = st_result;
    cond[dsm_pkg::BIT_ALARM1+1:dsm_pkg::BIT_ALARM1] = alarm_active;
    cond[dsm_pkg::BIT_FLASH_SUM] = mem_result;
    cond[dsm_pkg::BIT_ST_DIAG]   = |st_result;
    cond[dsm_pkg::BIT_OVERRANGE] = overrange;
    cond[dsm_pkg::BIT_LINK_FAIL] = link_fail;
    cond[dsm_pkg::BIT_FLASH_UPD] = flash_update_fail;
    event_now = '0;
    if (selftest_done) begin
      event_now[dsm_pkg::BIT_ACC_Z:dsm_pkg::BIT_GYR_X] = selftest_fail;
      event_now[dsm_pkg::BIT_ST_DIAG] = |selftest_fail;
    end
    event_now[dsm_pkg::BIT_FLASH_SUM] = mem_done && mem_fail;
    next_status = status;
    if (stat_rd_en) begin
      next_status = '0;
    end
    // Setting is applied after clearing so a coincident event survives.
    next_status = next_status
                | ((sample_tick ? cond : 16'h0000) | event_now)
                & dsm_pkg::STICKY_MASK;
    next_status[dsm_pkg::BIT_SUPPLY_HI] = supply_over;
    next_status[dsm_pkg::BIT_SUPPLY_LO] = supply_under;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= dsm_pkg::STAT_RESET;
    end else begin
      status <= next_status;
    end
  end

  assign stat_rd_data = status;

  // ==========================================================================
  // Checks.
  property p_read_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (stat_rd_en && !sample_tick && !selftest_done && !mem_done)
      |=> (status & dsm_pkg::STICKY_MASK) == 16'h0000;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear the error flags");

  property p_reassert;
    @(posedge clk_sys) disable iff (!rst_n)
      (sample_tick && overrange) |=> status[dsm_pkg::BIT_OVERRANGE];
  endproperty
  a_reassert: assert property (p_reassert)
    else $error("overrange flag not set on sample cycle");

  property p_coincident;
    @(posedge clk_sys) disable iff (!rst_n)
      (stat_rd_en && sample_tick && link_fail)
      |=> status[dsm_pkg::BIT_LINK_FAIL];
  endproperty
  a_coincident: assert property (p_coincident)
    else $error("link flag lost on coincident read");

  property p_supply;
    @(posedge clk_sys) disable iff (!rst_n)
      ##1 status[dsm_pkg::BIT_SUPPLY_HI] == $past(supply_over)
       && status[dsm_pkg::BIT_SUPPLY_LO] == $past(supply_under);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply flags do not follow the monitors");

  property p_unused;
    @(posedge clk_sys) disable iff (!rst_n)
      !status[dsm_pkg::BIT_UNUSED];
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused status bit set");

  property p_mem_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_done |=> !ctrl[dsm_pkg::BIT_MEM_TEST];
  endproperty
  a_mem_clear: assert property (p_mem_clear)
    else $error("memory test bit did not clear on completion");

  property p_mem_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      (mem_done && mem_fail) |=> status[dsm_pkg::BIT_FLASH_SUM];
  endproperty
  a_mem_flag: assert property (p_mem_flag)
    else $error("checksum failure not flagged");

  property p_selftest;
    @(posedge clk_sys) disable iff (!rst_n)
      (selftest_done && selftest_fail[5])
      |=> status[dsm_pkg::BIT_ACC_Z] && status[dsm_pkg::BIT_ST_DIAG]
          && !ctrl[dsm_pkg::BIT_SELF_TEST];
  endproperty
  a_selftest: assert property (p_selftest)
    else $error("self-test failure not recorded");
endmodule // dsm_diag

// ---- dsm_pkg.sv ----
/*
 * Constants shared by the diagnostic status and memory test logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dsm_pkg;
  // ==========================================================================
  // Status word layout.
  localparam int unsigned STAT_W         = 16;
  localparam logic [15:0] STAT_RESET     = 16'h0000;
  localparam int unsigned BIT_ACC_Z      = 15;
  localparam int unsigned BIT_ACC_X      = 13;
  localparam int unsigned BIT_GYR_X      = 10;
  localparam int unsigned BIT_ALARM1     = 8;
  localparam int unsigned BIT_UNUSED     = 7;
  localparam int unsigned BIT_FLASH_SUM  = 6;
  localparam int unsigned BIT_ST_DIAG    = 5;
  localparam int unsigned BIT_OVERRANGE  = 4;
  localparam int unsigned BIT_LINK_FAIL  = 3;
  localparam int unsigned BIT_FLASH_UPD  = 2;
  localparam int unsigned BIT_SUPPLY_HI  = 1;
  localparam int unsigned BIT_SUPPLY_LO  = 0;
  localparam logic [15:0] STICKY_MASK    = 16'hFF7C;
  // ==========================================================================
  // Miscellaneous control register layout.
  localparam logic [15:0] CTRL_RESET     = 16'h0006;
  localparam logic [15:0] CTRL_MASK      = 16'h0FC7;
  localparam int unsigned BIT_MEM_TEST   = 11;
  localparam int unsigned BIT_SELF_TEST  = 10;
  // ==========================================================================
  // Memory test sequencer states, Gray coded along the walk.
  typedef enum logic [1:0] {
    DSM_IDLE  = 2'b00,
    DSM_ISSUE = 2'b01,
    DSM_ACC   = 2'b11,
    DSM_DONE  = 2'b10
  } dsm_state_t;
endpackage

// ---- dsm_memtest.sv ----
/*
 * Flash checksum engine: sums all words but the last and compares the sum
 * with the last word, which holds the stored checksum.
 * Assumes a flash read port with one cycle of latency and a synced reset.
 */
`timescale 1ns/1ps
module dsm_memtest #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_W = 16
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Request and result.
  input  wire logic              start,
  output logic                   busy,
  output logic                   done,
  output logic                   fail,
  // Flash read port.
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] flash_rdata
);
  initial begin
    if (ADDR_W < 1 || DATA_W < 1) begin
      $error("dsm_memtest: widths must be at least one");
    end
  end

  localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};

  dsm_pkg::dsm_state_t state;
  dsm_pkg::dsm_state_t next_state;
  logic [DATA_W-1:0]   sum;
  logic [DATA_W-1:0]   next_sum;
  logic [ADDR_W-1:0]   next_addr;
  logic                next_fail;

  // ==========================================================================
  // Sequencer.
  always_comb begin
    next_state = state;
    next_sum   = sum;
    next_addr  = flash_addr;
    next_fail  = fail;
    case (state)
      dsm_pkg::DSM_IDLE: begin
        if (start) begin
          next_state = dsm_pkg::DSM_ISSUE;
          next_sum   = '0;
          next_addr  = '0;
        end
      end
      dsm_pkg::DSM_ISSUE: begin
        next_state = dsm_pkg::DSM_ACC;
      end
      dsm_pkg::DSM_ACC: begin
        if (flash_addr == LAST_ADDR) begin
          next_fail  = (sum != flash_rdata);
          next_state = dsm_pkg::DSM_DONE;
        end else begin
          next_sum   = sum + flash_rdata;
          next_addr  = flash_addr + 1'b1;
          next_state = dsm_pkg::DSM_ISSUE;
        end
      end
      dsm_pkg::DSM_DONE: begin
        next_state = dsm_pkg::DSM_IDLE;
      end
      default: begin
        next_state = dsm_pkg::DSM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= dsm_pkg::DSM_IDLE;
      sum        <= '0;
      flash_addr <= '0;
      fail       <= 1'b0;
    end else begin
      state      <= next_state;
      sum        <= next_sum;
      flash_addr <= next_addr;
      fail       <= next_fail;
    end
  end

  assign busy = (state != dsm_pkg::DSM_IDLE);
  assign done = (state == dsm_pkg::DSM_DONE);

  // ==========================================================================
  // Checks.
  property p_done_single;
    @(posedge clk_sys) disable iff (!rst_n)
      done |=> !done && !busy;
  endproperty
  a_done_single: assert property (p_done_single)
    else $error("done lasted more than one cycle");

  property p_start_runs;
    @(posedge clk_sys) disable iff (!rst_n)
      (start && !busy) |=> busy ##1 (flash_addr == '0) && busy;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not launch a checksum walk");
endmodule // dsm_memtest

// ---- dsm_flash_model.sv ----
/*
 * Flash memory model behind the checksum engine's read port.
 * Assumes one cycle of read latency; the last word holds the sum of the
 * others unless the bench asks for a corrupted checksum.
 */
`timescale 1ns/1ps
module dsm_flash_model #(
  parameter int unsigned AW = 2
) (
  // Clock.
  input  wire logic          clk_sys,
  // Read port.
  input  wire logic [AW-1:0] addr,
  input  wire logic          corrupt,
  output logic [15:0]        rdata
);
  // ==========================================================================
  // Contents.
  logic [15:0] mem [2**AW];
  logic [15:0] sum;

  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = 16'h0A5C + 16'h1111 * 16'(i);
      if (i < 2**AW - 1) begin
        sum = sum + mem[i];
      end
    end
    mem[2**AW-1] = sum ^ {15'h0000, corrupt};
  end

  always_ff @(posedge clk_sys) begin
    rdata <= mem[addr];
  end
endmodule // dsm_flash_model

// ---- dsm_diag_tb.sv ----
/*
 * Self-checking bench for the diagnostic status block.
 * Assumes dsm_diag and dsm_flash_model are compiled before it.
 */
`timescale 1ns/1ps
module dsm_diag_tb;
  localparam int unsigned AW = 2;
  // ==========================================================================
  // Stimulus and observation.
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        ctrl_wr_en = 1'b0;
  logic [15:0] ctrl_wr_data = 16'h0000;
  logic [15:0] ctrl_rd_data;
  logic        stat_rd_en = 1'b0;
  logic [15:0] stat_rd_data;
  logic        sample_tick = 1'b0;
  logic [1:0]  alarm_active = 2'b00;
  logic        overrange = 1'b0;
  logic        link_fail = 1'b0;
  logic        flash_update_fail = 1'b0;
  logic        supply_over = 1'b0;
  logic        supply_under = 1'b0;
  logic        selftest_start;
  logic        selftest_done = 1'b0;
  logic [5:0]  selftest_fail = 6'h00;
  logic [AW-1:0] flash_addr;
  logic [15:0] flash_rdata;
  logic        corrupt = 1'b0;
  logic [31:0] rnd = 32'h41F6F97F;
  logic [15:0] e;
  logic [15:0] exp_q [$];
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n;

  initial forever #10 clk_sys = ~clk_sys;

  dsm_diag #(.FLASH_ADDR_W(AW)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_data(ctrl_wr_data),
    .ctrl_rd_data(ctrl_rd_data),
    .stat_rd_en(stat_rd_en), .stat_rd_data(stat_rd_data),
    .sample_tick(sample_tick), .alarm_active(alarm_active),
    .overrange(overrange), .link_fail(link_fail),
    .flash_update_fail(flash_update_fail),
    .supply_over(supply_over), .supply_under(supply_under),
    .selftest_start(selftest_start), .selftest_done(selftest_done),
    .selftest_fail(selftest_fail),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata)
  );

  dsm_flash_model #(.AW(AW)) u_flash (
    .clk_sys(clk_sys), .addr(flash_addr), .corrupt(corrupt),
    .rdata(flash_rdata)
  );

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] ex);
    check_count++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [15:0] ex);
    exp_q.push_back(ex);
    stat_rd_en <= 1'b1;
    @(posedge clk_sys);
    stat_rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic tick;
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Writes the control register and checks the self-test start pulse.
  // The pulse is looked at on the edge that takes the write, before the
  // control register moves; the task returns one edge later, when the
  // written value stands on the read port.
  task automatic wr(input logic [15:0] d, input logic st);
    ctrl_wr_en <= 1'b1;
    ctrl_wr_data <= d;
    @(posedge clk_sys);
    chk("start", {15'h0000, selftest_start}, {15'h0000, st});
    ctrl_wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The value on the port in the read strobe cycle is the value read.
  always @(posedge clk_sys) begin
    if (stat_rd_en === 1'b1 && exp_q.size() > 0) begin
      chk("stat", stat_rd_data, exp_q.pop_front());
    end
  end

  initial begin
    #40000;
    n_mismatch++;
    test_done();
  end

  // ==========================================================================
  // Tests.
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(3);
    rd(16'h0000);
    chk("ctrl", ctrl_rd_data, 16'h0006);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      {flash_update_fail, link_fail, overrange, alarm_active} <= rnd[4:0];
      e = {6'h00, rnd[1:0], 3'b000, rnd[2], rnd[3], rnd[4], 2'b00};
      tick();
      rd(e);
      rd(16'h0000);
      tick();
      rd(e);
    end
    {flash_update_fail, link_fail, overrange, alarm_active} <= 5'h0C;
    exp_q.push_back(16'h0000);
    stat_rd_en <= 1'b1;
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    stat_rd_en <= 1'b0;
    sample_tick <= 1'b0;
    overrange <= 1'b0;
    link_fail <= 1'b0;
    @(posedge clk_sys);
    rd(16'h0018);
    $display("test sticky flags done");
    for (int k = 0; k < 2; k++) begin
      {supply_over, supply_under} <= 2'b10 >> k;
      cyc(2);
      rd(16'h0002 >> k);
      rd(16'h0002 >> k);
      {supply_over, supply_under} <= 2'b00;
      cyc(2);
      rd(16'h0000);
    end
    $display("test supply done");
    for (int k = 0; k < 2; k++) begin
      corrupt <= (k == 0);
      wr(16'h0800, 1'b0);
      chk("mt_run", {15'h0000, ctrl_rd_data[11]}, 16'h0001);
      n = 0;
      while (ctrl_rd_data[11] !== 1'b0 && n < 40) begin
        @(posedge clk_sys);
        n++;
      end
      chk("mt_end", ctrl_rd_data, 16'h0000);
      rd((k == 0) ? 16'h0040 : 16'h0000);
    end
    $display("test memory check done");
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      wr(16'h0400, 1'b1);
      // The first run always fails the Z accelerometer axis.
      e[5:0] = rnd[5:0] | {i == 0, 5'h00};
      chk("st_run", {15'h0000, ctrl_rd_data[10]}, 16'h0001);
      cyc(2);
      selftest_fail <= e[5:0];
      selftest_done <= 1'b1;
      @(posedge clk_sys);
      selftest_done <= 1'b0;
      @(posedge clk_sys);
      chk("st_end", {15'h0000, ctrl_rd_data[10]}, 16'h0000);
      rd({e[5:0], 4'h0, |e[5:0], 5'h00});
    end
    $display("test self-test done");
    // A reset in mid-run must also drop the latched self-test outcome.
    tick();
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(3);
    tick();
    rd(16'h0000);
    chk("ctrl", ctrl_rd_data, 16'h0006);
    $display("test mid-run reset done");
    test_done();
  end
endmodule // dsm_diag_tb
